// ===== logic/gptp_params.svh
// Behaviour
// - 16-bit counter counts up, down or center
// - power-of-two prescale, divide 1 to 32768
// - two independent timers, optional sync link
// - four channels: off, capture, compare, PWM
// - clock from pclk, 32k, 1 kHz or pin
// - update interrupt on wrap or init
// - trigger, capture and compare interrupts
// - quadrature encoder inputs
// - trigger input as clock, gated by mask pin
// - timer inputs leave pins shared
// - enabled output channel overrides other peripheral
// - remap bit 0 port a, 1 port b
// - first timer uses fixed pins
// - second timer pins per remap bits
// - clock and mask used only externally clocked
// - 4-bit exponent, 16-bit prescale counter
// - update on wrap unless update disabled
// - count enable follows enable bit one cycle later, held low once a one-pulse run wraps
`ifndef GPTP_PARAMS_SVH
`define GPTP_PARAMS_SVH
`define GPTP_CNT_W 16
`define GPTP_EXP_W 4
`define GPTP_NCH 4
`define GPTP_CLK_PCLK 2'h0
`define GPTP_CLK_32K 2'h1
`define GPTP_CLK_1K 2'h2
`define GPTP_CLK_EXT 2'h3
`define GPTP_DIR_UP 2'h0
`define GPTP_DIR_DOWN 2'h1
`define GPTP_DIR_CENTER 2'h2
`define GPTP_CH_OFF 2'h0
`define GPTP_CH_CAPTURE 2'h1
`define GPTP_CH_COMPARE 2'h2
`define GPTP_CH_PWM 2'h3
`define GPTP_REMAP_RESET 4'h0
`endif

// ===== logic/gptp_pkg.sv
package gptp_pkg;
   // per-timer software control
   typedef struct packed {
      logic enable;
      logic update_disable;
      logic update_request;
      logic one_pulse;
      logic [1:0] dir_mode;
      logic [1:0] clk_sel;
      logic [3:0] prescale_exponent;
      logic [15:0] reload;
      logic sync_start;
      logic encoder_mode;
   } gptp_ctrl_s;
   // per-channel configuration
   typedef struct packed {
      logic [1:0] mode;
      logic enable;
      logic [15:0] compare;
   } gptp_chan_s;
   // per-timer event pulses
   typedef struct packed {
      logic update;
      logic trigger;
      logic [3:0] capture;
      logic [3:0] compare;
   } gptp_evt_s;
   typedef enum logic [1:0] {
      GPTP_IDLE = 2'b00,
      GPTP_RUN = 2'b01,
      GPTP_DONE = 2'b11
   } gptp_state_e;
endpackage : gptp_pkg

// ===== logic/gptp_timer_pair.sv
`timescale 1ns/1ps
`include "gptp_params.svh"
module gptp_timer_pair
   import gptp_pkg::*;
#(
   parameter int CNT_W = `GPTP_CNT_W
)
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic tick_32k_in, // one-cycle enable from divider
   input wire logic tick_1k_in, // one-cycle enable from divider
   input wire logic [7:0] port_a_in, // raw pins
   input wire logic [7:0] port_b_in,
   input wire gptp_ctrl_s ctrl_in [2],
   input wire gptp_chan_s chan_in [2][4],
   input wire logic [3:0] channel_remap_bit_in, // second timer option
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe_n_out, // low while timer drives
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe_n_out,
   output logic [15:0] count_out [2],
   output logic [15:0] capture_out [2][4],
   output logic direction_down_out [2],
   output gptp_evt_s event_out [2]
);
   // elaboration check: the counter and prescaler logic is 16 bits only
   if (CNT_W != 16)
   begin : g_bad_width
      $error("only 16-bit counters supported");
   end

   // three-stage synchronisers on both ports
   logic [7:0] pa1, pa2, pa3, pb1, pb2, pb3;
   logic [7:0] pa_s, pb_s; // debounced-agreed level
   always_ff @(posedge mclk_in)
   begin
      pa1 <= port_a_in;
      pa2 <= pa1;
      pa3 <= pa2;
      pb1 <= port_b_in;
      pb2 <= pb1;
      pb3 <= pb2;
   end
   // a change counts only when stages two and three agree
   logic [7:0] next_pa_s, next_pb_s;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         next_pa_s[i] = (pa2[i] == pa3[i]) ? pa3[i] : pa_s[i];
         next_pb_s[i] = (pb2[i] == pb3[i]) ? pb3[i] : pb_s[i];
      end
   end
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         pa_s <= 8'h00;
         pb_s <= 8'h00;
      end
      else
      begin
         pa_s <= next_pa_s;
         pb_s <= next_pb_s;
      end
   end

   // remap register, reset to port a
   logic [3:0] remap;
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         remap <= `GPTP_REMAP_RESET;
      else
         remap <= channel_remap_bit_in;
   end

   // pin index maps; decoding used by input and output paths
   function automatic logic [3:0] chan_pin(input int t, input int c,
                                           input logic rm);
      // {port_b, bit[2:0]}
      logic [3:0] r;
      r = 4'h0;
      if (t == 0)
         case (c)
            0: r = 4'hE;
            1: r = 4'hF;
            2: r = 4'h6;
            default: r = 4'h7;
         endcase
      else if (rm)
         r = {1'b1, 3'(c + 1)};
      else
         case (c)
            0: r = 4'h0;
            1: r = 4'h3;
            2: r = 4'h1;
            default: r = 4'h2;
         endcase
      return r;
   endfunction : chan_pin

   logic [3:0] ch_out [2];
   logic [3:0] ch_oe [2];
   logic [3:0] ch_in [2];
   logic clk_pin [2];
   logic msk_pin [2];
   logic [1:0] trig; // update pulses shared only as sync link

   // route pins: inputs are read without claiming pins
   always_comb
   begin
      logic [3:0] p;
      p = 4'h0;
      clk_pin[0] = pb_s[0];
      msk_pin[0] = pb_s[5];
      clk_pin[1] = pb_s[5];
      msk_pin[1] = pb_s[0];
      for (int t = 0; t < 2; t++)
         for (int c = 0; c < 4; c++)
         begin
            p = chan_pin(t, c, remap[c]);
            ch_in[t][c] = p[3] ? pb_s[p[2:0]] : pa_s[p[2:0]];
         end
   end

   // drive pins where an output channel is enabled
   always_comb
   begin
      logic [3:0] p;
      p = 4'h0;
      port_a_out = 8'h00;
      port_b_out = 8'h00;
      port_a_oe_n_out = 8'hFF;
      port_b_oe_n_out = 8'hFF;
      for (int t = 0; t < 2; t++)
         for (int c = 0; c < 4; c++)
         begin
            p = chan_pin(t, c, remap[c]);
            if (ch_oe[t][c])
            begin
               if (p[3])
               begin
                  port_b_out[p[2:0]] = ch_out[t][c];
                  port_b_oe_n_out[p[2:0]] = 1'b0;
               end
               else
               begin
                  port_a_out[p[2:0]] = ch_out[t][c];
                  port_a_oe_n_out[p[2:0]] = 1'b0;
               end
            end
         end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_tim
         logic [15:0] cnt, next_cnt;
         logic [15:0] psc, next_psc;
         logic [3:0] exp_sh, next_exp_sh;
         logic [15:0] arr_sh, next_arr_sh;
         logic internal_count_enable, next_internal_count_enable; // internal_count_enable
         logic down, next_down;
         logic clk_d, msk_d, next_clk_d;
         logic [3:0] in_d;
         logic tick, wrap, upd;
         gptp_state_e st, next_st;
         logic [15:0] cap [4];
         logic [15:0] next_cap [4];
         gptp_evt_s ev;
         logic start;

         // external trigger: mask pin gates clock pin
         always_comb
         begin
            logic base;
            logic [15:0] lim;
            base = 1'b0;
            lim = 16'h0;
            ev = '0;
            start = ctrl_in[g].enable |
                    (ctrl_in[g].sync_start & trig[1 - g]);
            next_internal_count_enable = start & (st != GPTP_DONE);
            next_clk_d = clk_pin[g];
            case (ctrl_in[g].clk_sel)
               `GPTP_CLK_PCLK: base = 1'b1;
               `GPTP_CLK_32K: base = tick_32k_in;
               `GPTP_CLK_1K: base = tick_1k_in;
               default: base = clk_pin[g] & ~clk_d & msk_pin[g];
            endcase
            ev.trigger = (ctrl_in[g].clk_sel == `GPTP_CLK_EXT) &
                         internal_count_enable & base;
            // quadrature: count on channel 1 edges, direction from 2
            if (ctrl_in[g].encoder_mode)
               base = ch_in[g][0] ^ in_d[0];
            // power-of-two prescaler
            lim = 16'((32'h1 << exp_sh) - 1);
            next_psc = psc;
            tick = 1'b0;
            if (internal_count_enable & base)
            begin
               if (psc >= lim)
               begin
                  next_psc = 16'h0;
                  tick = 1'b1;
               end
               else
                  next_psc = psc + 16'h1;
            end
            next_cnt = cnt;
            next_down = down;
            wrap = 1'b0;
            if (tick)
               case (ctrl_in[g].encoder_mode ? `GPTP_DIR_UP
                     : ctrl_in[g].dir_mode)
                  `GPTP_DIR_DOWN:
                  begin
                     next_down = 1'b1;
                     wrap = (cnt == 16'h0);
                     next_cnt = wrap ? arr_sh : cnt - 16'h1;
                  end
                  `GPTP_DIR_CENTER:
                  begin
                     // turn at reload-1 and at 1
                     if (!down)
                     begin
                        wrap = (cnt >= arr_sh - 16'h1);
                        next_down = wrap;
                        next_cnt = wrap ? arr_sh : cnt + 16'h1;
                     end
                     else
                     begin
                        wrap = (cnt <= 16'h1);
                        next_down = ~wrap;
                        next_cnt = wrap ? 16'h0 : cnt - 16'h1;
                     end
                  end
                  default:
                  begin
                     next_down = 1'b0;
                     if (ctrl_in[g].encoder_mode &&
                         (ch_in[g][1] ^ ch_in[g][0]))
                     begin
                        next_down = 1'b1;
                        wrap = (cnt == 16'h0);
                        next_cnt = wrap ? arr_sh : cnt - 16'h1;
                     end
                     else
                     begin
                        wrap = (cnt >= arr_sh);
                        next_cnt = wrap ? 16'h0 : cnt + 16'h1;
                     end
                  end
               endcase
            upd = (wrap & ~ctrl_in[g].update_disable) |
                  ctrl_in[g].update_request;
            ev.update = upd;
            if (ctrl_in[g].update_request)
            begin
               next_cnt = (ctrl_in[g].dir_mode == `GPTP_DIR_DOWN)
                          ? arr_sh : 16'h0;
               // initialisation also sets the direction, else a stale
               // down flag lingers until the next tick
               next_down = (ctrl_in[g].dir_mode == `GPTP_DIR_DOWN);
               next_psc = 16'h0;
            end
            next_exp_sh = upd ? ctrl_in[g].prescale_exponent : exp_sh;
            next_arr_sh = upd ? ctrl_in[g].reload : arr_sh;
            next_st = st;
            case (st)
               GPTP_IDLE: next_st = start ? GPTP_RUN : GPTP_IDLE;
               GPTP_RUN:
                  if (!start)
                     next_st = GPTP_IDLE;
                  else if (wrap & ctrl_in[g].one_pulse)
                     next_st = GPTP_DONE;
               GPTP_DONE: next_st = start ? GPTP_DONE : GPTP_IDLE;
               default: next_st = GPTP_IDLE;
            endcase
            // channels: capture on rising edge, compare on match
            for (int c = 0; c < 4; c++)
            begin
               next_cap[c] = cap[c];
               ch_oe[g][c] = chan_in[g][c].enable &&
                  chan_in[g][c].mode >= `GPTP_CH_COMPARE;
               ch_out[g][c] = (chan_in[g][c].mode == `GPTP_CH_PWM)
                  ? (cnt < chan_in[g][c].compare)
                  : (cnt >= chan_in[g][c].compare);
               if (chan_in[g][c].enable &&
                   chan_in[g][c].mode == `GPTP_CH_CAPTURE &&
                   ch_in[g][c] && !in_d[c])
               begin
                  next_cap[c] = cnt;
                  ev.capture[c] = 1'b1;
               end
               ev.compare[c] = chan_in[g][c].enable && tick &&
                  chan_in[g][c].mode >= `GPTP_CH_COMPARE &&
                  next_cnt == chan_in[g][c].compare;
            end
         end
         assign trig[g] = ev.update;

         // register timer state
         always_ff @(posedge mclk_in)
         begin
            if (srst_in)
            begin
               cnt <= 16'h0;
               psc <= 16'h0;
               exp_sh <= 4'h0;
               arr_sh <= 16'hFFFF;
               internal_count_enable <= 1'b0;
               down <= 1'b0;
               clk_d <= 1'b0;
               msk_d <= 1'b0;
               in_d <= 4'h0;
               st <= GPTP_IDLE;
               cap <= '{default: 16'h0};
               event_out[g] <= '0;
            end
            else
            begin
               cnt <= next_cnt;
               psc <= next_psc;
               exp_sh <= next_exp_sh;
               arr_sh <= next_arr_sh;
               internal_count_enable <= next_internal_count_enable;
               down <= next_down;
               clk_d <= next_clk_d;
               msk_d <= msk_pin[g];
               in_d <= ch_in[g];
               st <= next_st;
               cap <= next_cap;
               event_out[g] <= ev;
            end
         end
         assign count_out[g] = cnt;
         assign direction_down_out[g] = down;
         assign capture_out[g] = cap;
      end
   endgenerate
endmodule : gptp_timer_pair

// ===== verification/gptp_timer_pair_asserts.sv
`timescale 1ns/1ps
`include "gptp_params.svh"
module gptp_timer_pair_asserts
   import gptp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire gptp_ctrl_s ctrl_in [2],
   input wire gptp_chan_s chan_in [2][4],
   input wire logic [3:0] channel_remap_bit_in,
   input wire logic [7:0] port_a_oe_n_out,
   input wire logic [7:0] port_b_oe_n_out,
   input wire logic [15:0] count_out [2],
   input wire logic direction_down_out [2],
   input wire gptp_evt_s event_out [2]
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   // a channel owns its pin only as an enabled output
   function automatic logic drv(gptp_chan_s c);
      return c.enable && (c.mode inside {`GPTP_CH_COMPARE, `GPTP_CH_PWM});
   endfunction : drv
   // enable rise: one idle edge, then the first count
   sequence s_go;
      $rose(ctrl_in[0].enable) && !ctrl_in[0].update_request &&
         ctrl_in[0].prescale_exponent == 4'h0 &&
         ctrl_in[0].clk_sel == `GPTP_CLK_PCLK && !ctrl_in[0].encoder_mode;
   endsequence
   sequence s_first;
      $stable(count_out[0]) ##1 count_out[0] != $past(count_out[0]);
   endsequence
   property p_go;
      s_go |=> s_first;
   endproperty
   a_go: assert property (p_go) else $error("late or early count");
   property p_stop;
      (!ctrl_in[0].enable && !ctrl_in[0].update_request) [*2]
         |=> $stable(count_out[0]);
   endproperty
   a_stop: assert property (p_stop) else $error("count moved while off");
   property p_udis;
      (ctrl_in[0].update_disable && !ctrl_in[0].update_request) [*3]
         |=> !event_out[0].update;
   endproperty
   a_udis: assert property (p_udis) else $error("update not held off");
   property p_req;
      $rose(ctrl_in[0].update_request) |-> ##[1:2] event_out[0].update;
   endproperty
   a_req: assert property (p_req) else $error("soft update missing");
   property p_dir;
      (ctrl_in[0].dir_mode == `GPTP_DIR_UP) [*3] |-> !direction_down_out[0];
   endproperty
   a_dir: assert property (p_dir) else $error("up timer shows down");
   property p_t1c1;
      drv(chan_in[0][0]) |-> !port_b_oe_n_out[6];
   endproperty
   a_t1c1: assert property (p_t1c1) else $error("first ch1 pin idle");
   property p_t1c3;
      drv(chan_in[0][2]) |-> !port_a_oe_n_out[6];
   endproperty
   a_t1c3: assert property (p_t1c3) else $error("first ch3 pin idle");
   property p_t2a;
      drv(chan_in[1][1]) && !$past(channel_remap_bit_in[1])
         |-> !port_a_oe_n_out[3] && port_b_oe_n_out[2];
   endproperty
   a_t2a: assert property (p_t2a) else $error("ch2 default pin wrong");
   property p_t2b;
      drv(chan_in[1][1]) && $past(channel_remap_bit_in[1])
         |-> !port_b_oe_n_out[2] && port_a_oe_n_out[3];
   endproperty
   a_t2b: assert property (p_t2b) else $error("ch2 remap pin wrong");
   property p_off;
      !drv(chan_in[0][0]) |-> port_b_oe_n_out[6];
   endproperty
   a_off: assert property (p_off) else $error("pin taken while off");
endmodule : gptp_timer_pair_asserts
bind gptp_timer_pair gptp_timer_pair_asserts u_chk (.mclk_in(mclk_in),
   .srst_in(srst_in), .ctrl_in(ctrl_in), .chan_in(chan_in),
   .channel_remap_bit_in(channel_remap_bit_in),
   .port_a_oe_n_out(port_a_oe_n_out), .port_b_oe_n_out(port_b_oe_n_out),
   .count_out(count_out), .direction_down_out(direction_down_out),
   .event_out(event_out));

// ===== verification/gptp_pin_model.sv
`timescale 1ns/1ps
module gptp_pin_model
(
   input wire logic mclk_in,
   input wire logic run_in, // toggle the clock pin while high
   input wire logic mask_in, // level on the mask pin
   output logic [7:0] port_a_out,
   output logic [7:0] port_b_out
);
   logic [1:0] div = 2'h0; // slow edges outlast the pin synchroniser
   logic clk_pin = 1'b0; // stands still outside a burst
   // one toggle every four cycles while running
   always_ff @(posedge mclk_in)
   begin
      div <= run_in ? div + 2'h1 : 2'h0;
      if (run_in && div == 2'h3)
         clk_pin <= !clk_pin;
   end
   // timer output pins are left to the timer alone
   assign port_a_out = 8'h00;
   // clock on bit 0, mask on bit 5 for the first timer
   assign port_b_out = {2'h0, mask_in, 4'h0, clk_pin};
endmodule : gptp_pin_model

// ===== verification/tb_gptp_timer_pair.sv
`timescale 1ns/1ps
`include "gptp_params.svh"
module tb_gptp_timer_pair
   import gptp_pkg::*;
;
   logic mclk_in = 1'b0; // 40 MHz
   logic srst_in = 1'b1;
   gptp_ctrl_s ctrl [2];
   gptp_chan_s chan [2][4];
   logic [3:0] remap = 4'h0;
   logic run = 1'b0;
   logic mask = 1'b0;
   logic tick_1k = 1'b0; // enable pulses every other cycle for the 1 kHz source
   logic [7:0] pa, pb, pa_oe_n, pb_oe_n;
   logic [15:0] cnt [2];
   logic dn [2];
   gptp_evt_s evt [2];
   int errors = 0;
   int comparisons = 0;
   int n;
   logic [15:0] base;
   byte pa2 [4] = '{0, 3, 1, 2}; // second timer default pins
   initial
   begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   gptp_pin_model pins (.mclk_in(mclk_in), .run_in(run), .mask_in(mask),
      .port_a_out(pa), .port_b_out(pb));
   gptp_timer_pair dut (.mclk_in(mclk_in), .srst_in(srst_in),
      .tick_32k_in(1'b0), .tick_1k_in(tick_1k), .port_a_in(pa),
      .port_b_in(pb), .ctrl_in(ctrl), .chan_in(chan),
      .channel_remap_bit_in(remap), .port_a_out(), .port_a_oe_n_out(pa_oe_n),
      .port_b_out(), .port_b_oe_n_out(pb_oe_n), .count_out(cnt),
      .capture_out(), .direction_down_out(dn), .event_out(evt));
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   // count edges up to the next update pulse, bounded
   task automatic wait_upd(input int t, output int k);
      k = 0;
      do
      begin
         @(posedge mclk_in);
         k++;
      end while (evt[t].update !== 1'b1 && k < 3000);
      if (k >= 3000)
      begin
         errors++;
         finish_test();
      end
   endtask : wait_upd
   // load shadows, then start the timer a clear cycle later
   task automatic start(input int t);
      @(posedge mclk_in);
      ctrl[t].update_request <= 1'b1;
      @(posedge mclk_in);
      ctrl[t].update_request <= 1'b0;
      @(posedge mclk_in);
      ctrl[t].enable <= 1'b1;
   endtask : start
   initial
   begin
      foreach (ctrl[i]) ctrl[i] = '0;
      foreach (chan[i, j]) chan[i][j] = '0;
      repeat (4) @(posedge mclk_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      chk("reset count", cnt[0], 16'h0000);
      chk("reset oe a", pa_oe_n, 16'h00FF);
      chk("reset oe b", pb_oe_n, 16'h00FF);
      // period = (reload + 1) << exponent, both directions, both timers
      for (int k = 0; k < 4; k++)
      begin
         automatic int t = (k == 3);
         automatic logic [3:0] e = (k == 1) ? 4'h2 : {3'h0, k == 3};
         automatic logic [1:0] d = (k == 2) ? `GPTP_DIR_DOWN : `GPTP_DIR_UP;
         @(posedge mclk_in);
         ctrl[t].dir_mode <= d;
         ctrl[t].prescale_exponent <= e;
         ctrl[t].reload <= 16'h0003;
         start(t);
         base = cnt[0];
         wait_upd(t, n);
         wait_upd(t, n);
         chk("period", 16'(n), 16'(4 << e));
         chk("direction", 16'(dn[t]), 16'(k == 2));
         if (t == 1)
            chk("other timer", cnt[0], base);
         ctrl[t].enable <= 1'b0;
      end
      // held-off updates, then released
      @(posedge mclk_in);
      ctrl[0].update_disable <= 1'b1;
      ctrl[0].enable <= 1'b1;
      n = 0;
      repeat (40)
      begin
         @(posedge mclk_in);
         n += (evt[0].update === 1'b1);
      end
      chk("masked updates", 16'(n), 16'h0000);
      ctrl[0].update_disable <= 1'b0;
      wait_upd(0, n);
      chk("update back", 16'(n <= 8), 16'h0001);
      // output-enable pins for capture, compare and PWM on every channel, both remap settings
      for (int t = 0; t < 2; t++)
         for (int r = 0; r < 2; r++)
            for (int c = 0; c < 4; c++)
               for (int m = 1; m < 4; m++)
               begin
                  automatic logic [7:0] ea = 8'hFF;
                  automatic logic [7:0] eb = 8'hFF;
                  if (m != 1 && t == 0 && c < 2)
                     eb = ~(8'h01 << (c + 6));
                  else if (m != 1 && t == 0)
                     ea = ~(8'h01 << (c + 4));
                  else if (m != 1 && r == 1)
                     eb = ~(8'h01 << (c + 1));
                  else if (m != 1)
                     ea = ~(8'h01 << pa2[c]);
                  @(posedge mclk_in);
                  remap <= {4{r[0]}};
                  @(posedge mclk_in);
                  chan[t][c] <= '{mode: m[1:0], enable: 1'b1, compare: '0};
                  @(posedge mclk_in);
                  chk("pin oe a", pa_oe_n, ea);
                  chk("pin oe b", pb_oe_n, eb);
                  chan[t][c] <= '0;
               end
      // external clock pin counts only when selected and unmasked
      @(posedge mclk_in);
      ctrl[0].enable <= 1'b0;
      ctrl[0].dir_mode <= `GPTP_DIR_UP;
      ctrl[0].prescale_exponent <= 4'h0;
      ctrl[0].reload <= 16'hFFFF;
      ctrl[0].clk_sel <= `GPTP_CLK_EXT;
      start(0);
      for (int k = 0; k < 3; k++)
      begin
         repeat (4) @(posedge mclk_in);
         base = cnt[0];
         mask <= (k != 1);
         ctrl[0].clk_sel <= (k == 2) ? `GPTP_CLK_1K : `GPTP_CLK_EXT;
         run <= 1'b1;
         repeat (64)
         begin
            @(posedge mclk_in);
            tick_1k <= (k == 2) && !tick_1k;
         end
         run <= 1'b0;
         repeat (12) @(posedge mclk_in);
         chk("pin clock", cnt[0], base + ((k == 0) ? 16'h0008 : 16'h0)
            + ((k == 2) ? 16'h0020 : 16'h0));
      end
      finish_test();
   end
endmodule : tb_gptp_timer_pair
